/* File: mac_datapath.v */
// multiply-accumulate datapath with data memory and table read
`timescale 1ns/100ps
`include "mac_datapath_defs.vh"

// Overview of operation
// - 16x16 multiply into 32-bit product register
// - load_multiplicand copies memory word to multiplicand
// - multiply by memory word or instruction constant
// - immediate multiply constant is 13-bit signed
// - product load, add, subtract into accumulator
// - each multiply step takes one cycle
// - load_and_accumulate loads multiplicand, adds product
// - shift_word_up copies word upward, acc untouched
// - load-shift-accumulate: load, shift up, add product
// - product holds until next multiply
// - block interrupt right after any multiply
// - short loads take unsigned eight-bit immediate
// - table read: source acc, destination operand
// - table read moves 16-bit word, three cycles
module mac_datapath #(
  parameter DM_AW = 8,
  parameter PM_AW = 12
) (
  // clock and reset
  input  wire                   clock,
  input  wire                   sys_rst,
  // operation issue from the sequencer
  input  wire                   op_valid,
  input  wire [`OPCODE_W-1:0]   op_code,
  input  wire [DM_AW-1:0]       op_addr,
  input  wire [`IMM_MPY_W-1:0]  op_imm,
  input  wire                   op_aux_sel,
  output reg                    op_ready_ff,
  output reg                    op_done_ff,
  // interrupt boundary control
  output reg                    int_inhibit_ff,
  // program memory read port
  output reg                    pm_rd_ff,
  output reg  [PM_AW-1:0]       pm_addr_ff,
  input  wire [`OPND_W-1:0]     pm_rdata,
  // data memory load and inspect port
  input  wire                   dm_wr_en,
  input  wire [DM_AW-1:0]       dm_wr_addr,
  input  wire [`OPND_W-1:0]     dm_wr_data,
  input  wire [DM_AW-1:0]       dm_rd_addr,
  output reg  [`OPND_W-1:0]     dm_rd_data_ff,
  // architectural state
  output reg  [`ACC_W-1:0]      acc_ff,
  output reg  [`PROD_W-1:0]     product_ff,
  output reg  [`OPND_W-1:0]     multiplicand_ff,
  output reg  [`OPND_W-1:0]     aux0_ff,
  output reg  [`OPND_W-1:0]     aux1_ff
);

  localparam DM_DEPTH = 1 << DM_AW;

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  reg  [`OPND_W-1:0]   dmem [0:DM_DEPTH-1];
  reg  [1:0]           tr_state_ff;
  reg  [1:0]           nxt_tr_state;
  reg  [DM_AW-1:0]     tr_dest_ff;

  wire                 take;
  wire [`OPND_W-1:0]   dm_word;
  wire [DM_AW-1:0]     addr_up;
  wire                 addr_up_ok;
  wire [`OPND_W-1:0]   imm_ext;
  wire [`OPND_W-1:0]   mult_b;
  wire [`PROD_W-1:0]   mult_p;
  wire                 is_mpy;

  reg  [`ACC_W-1:0]    nxt_acc;
  reg  [`PROD_W-1:0]   nxt_product;
  reg  [`OPND_W-1:0]   nxt_multiplicand;
  reg                  op_dm_we;
  reg  [DM_AW-1:0]     op_dm_waddr;
  reg  [`OPND_W-1:0]   op_dm_wdata;

  // ----------------------------------------------------------------
  // operand paths
  // ----------------------------------------------------------------
  // ops are taken only while no table read is in flight
  assign take       = op_valid & op_ready_ff;
  assign dm_word    = dmem[op_addr];
  assign addr_up    = op_addr + {{(DM_AW-1){1'b0}}, 1'b1};
  // the top word has no higher neighbour, so its shift is dropped
  assign addr_up_ok = ~(&op_addr);
  assign imm_ext    = {{(`OPND_W-`IMM_MPY_W){op_imm[`IMM_MPY_W-1]}},
                       op_imm};
  // second operand from memory or immediate
  assign mult_b     = (op_code == `OP_MULTIPLY_IMM) ? imm_ext : dm_word;
  assign is_mpy     = (op_code == `OP_MULTIPLY_MEMORY) |
                      (op_code == `OP_MULTIPLY_IMM);

  mac_signed_mult #(
    .OPND_W  (`OPND_W)
  ) u_mult (
    .opnd_a  (multiplicand_ff),
    .opnd_b  (mult_b),
    .product (mult_p)
  );

  // ----------------------------------------------------------------
  // single-cycle operation decode
  // ----------------------------------------------------------------
  always @* begin
    nxt_acc          = acc_ff;
    nxt_product      = product_ff;
    nxt_multiplicand = multiplicand_ff;
    op_dm_we         = 1'b0;
    op_dm_waddr      = addr_up;
    op_dm_wdata      = dm_word;
    if (take) begin
      case (op_code)
        `OP_LOAD_MULTIPLICAND: begin
          nxt_multiplicand = dm_word;
        end
        `OP_MULTIPLY_MEMORY,
        `OP_MULTIPLY_IMM: begin
          nxt_product = mult_p;
        end
        `OP_PRODUCT_TO_ACC: begin
          nxt_acc = product_ff;
        end
        `OP_ADD_PRODUCT: begin
          nxt_acc = acc_ff + product_ff;
        end
        `OP_SUBTRACT_PRODUCT: begin
          nxt_acc = acc_ff - product_ff;
        end
        `OP_LOAD_AND_ACC: begin
          nxt_multiplicand = dm_word;
          nxt_acc          = acc_ff + product_ff;
        end
        `OP_SHIFT_WORD_UP: begin
          op_dm_we = addr_up_ok;
        end
        // load, shift up and accumulate together
        `OP_LOAD_SHIFT_ACC: begin
          nxt_multiplicand = dm_word;
          op_dm_we         = addr_up_ok;
          nxt_acc          = acc_ff + product_ff;
        end
        `OP_LOAD_ACC_SHORT: begin
          nxt_acc = {{(`ACC_W-`IMM_SHORT_W){1'b0}},
                     op_imm[`IMM_SHORT_W-1:0]};
        end
        default: begin
          nxt_acc = acc_ff;
        end
      endcase
    end
    // third cycle writes the fetched word
    if (tr_state_ff == `TR_WRITE) begin
      op_dm_we    = 1'b1;
      op_dm_waddr = tr_dest_ff;
      op_dm_wdata = pm_rdata;
    end
  end

  // ----------------------------------------------------------------
  // table-read sequencer
  // ----------------------------------------------------------------
  always @* begin
    case (tr_state_ff)
      `TR_IDLE: begin
        if (take && op_code == `OP_TABLE_READ) begin
          nxt_tr_state = `TR_FETCH;
        end else begin
          nxt_tr_state = `TR_IDLE;
        end
      end
      `TR_FETCH: begin
        nxt_tr_state = `TR_WRITE;
      end
      `TR_WRITE: begin
        nxt_tr_state = `TR_IDLE;
      end
      default: begin
        nxt_tr_state = `TR_IDLE;
      end
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      tr_state_ff <= `TR_IDLE;
      tr_dest_ff  <= {DM_AW{1'b0}};
      pm_rd_ff    <= 1'b0;
      pm_addr_ff  <= {PM_AW{1'b0}};
      op_ready_ff <= 1'b0;
    end else begin
      tr_state_ff <= nxt_tr_state;
      // busy for the two cycles after issue
      op_ready_ff <= (nxt_tr_state == `TR_IDLE);
      if (take && op_code == `OP_TABLE_READ) begin
        // source from acc, destination from operand
        pm_addr_ff <= acc_ff[PM_AW-1:0];
        tr_dest_ff <= op_addr;
        pm_rd_ff   <= 1'b1;
      end else begin
        pm_rd_ff   <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // data memory
  // ----------------------------------------------------------------
  // a datapath write beats a port load to the same cycle; the port
  // is meant for preloading while the sequencer is quiet
  always @(posedge clock) begin
    if (op_dm_we) begin
      dmem[op_dm_waddr] <= op_dm_wdata;
    end else if (dm_wr_en) begin
      dmem[dm_wr_addr] <= dm_wr_data;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      dm_rd_data_ff <= `RST_WORD16;
    end else begin
      dm_rd_data_ff <= dmem[dm_rd_addr];
    end
  end

  // ----------------------------------------------------------------
  // architectural registers
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      acc_ff          <= `RST_WORD32;
      product_ff      <= `RST_WORD32;
      multiplicand_ff <= `RST_WORD16;
      aux0_ff         <= `RST_WORD16;
      aux1_ff         <= `RST_WORD16;
    end else begin
      // every step retires at the next edge
      acc_ff          <= nxt_acc;
      product_ff      <= nxt_product;
      multiplicand_ff <= nxt_multiplicand;
      if (take && op_code == `OP_LOAD_AUX_SHORT) begin
        if (op_aux_sel) begin
          aux1_ff <= {{(`OPND_W-`IMM_SHORT_W){1'b0}},
                      op_imm[`IMM_SHORT_W-1:0]};
        end else begin
          aux0_ff <= {{(`OPND_W-`IMM_SHORT_W){1'b0}},
                      op_imm[`IMM_SHORT_W-1:0]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // completion and interrupt boundary
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      op_done_ff     <= 1'b0;
      int_inhibit_ff <= 1'b0;
    end else begin
      op_done_ff <= (take && op_code != `OP_TABLE_READ) ||
                    (tr_state_ff == `TR_WRITE);
      // hold off interrupts until the next op is taken
      // so the product can be moved out before any handler runs
      if (take) begin
        int_inhibit_ff <= is_mpy;
      end
    end
  end

endmodule

/* File: mac_datapath_defs.vh */
// constants for the multiply-accumulate datapath
`ifndef MAC_DATAPATH_DEFS_VH
`define MAC_DATAPATH_DEFS_VH

// ----------------------------------------------------------------
// operand and word widths
// ----------------------------------------------------------------
`define OPND_W          16
`define PROD_W          32
`define ACC_W           32
`define IMM_MPY_W       13
`define IMM_SHORT_W     8
`define OPCODE_W        4

// ----------------------------------------------------------------
// operation codes on op_code
// ----------------------------------------------------------------
`define OP_NOP               4'h0
`define OP_LOAD_MULTIPLICAND 4'h1
`define OP_MULTIPLY_MEMORY   4'h2
`define OP_MULTIPLY_IMM      4'h3
`define OP_PRODUCT_TO_ACC    4'h4
`define OP_ADD_PRODUCT       4'h5
`define OP_SUBTRACT_PRODUCT  4'h6
`define OP_LOAD_AND_ACC      4'h7
`define OP_SHIFT_WORD_UP     4'h8
`define OP_LOAD_SHIFT_ACC    4'h9
`define OP_TABLE_READ        4'hA
`define OP_LOAD_ACC_SHORT    4'hB
`define OP_LOAD_AUX_SHORT    4'hC

// ----------------------------------------------------------------
// table-read sequencer states
// ----------------------------------------------------------------
`define TR_IDLE   2'h0
`define TR_FETCH  2'h1
`define TR_WRITE  2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS      10
`define STEP_TIME_NS       10
`define STEP_CYCLES        ((`STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TABLE_READ_CYCLES  3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_WORD16  16'h0000
`define RST_WORD32  32'h0000_0000

`endif

/* File: mac_signed_mult.v */
// signed 16 x 16 multiplier with full 32-bit product
`timescale 1ns/100ps
module mac_signed_mult #(
  parameter OPND_W = 16
) (
  // operands
  input  wire [OPND_W-1:0]   opnd_a,
  input  wire [OPND_W-1:0]   opnd_b,
  // product
  output wire [2*OPND_W-1:0] product
);

  wire signed [OPND_W-1:0]   sa;
  wire signed [OPND_W-1:0]   sb;
  wire signed [2*OPND_W-1:0] sp;

  assign sa      = opnd_a;
  assign sb      = opnd_b;
  assign sp      = sa * sb;
  assign product = sp;

endmodule

/* File: mac_datapath_properties.sv */
// assertion checker for the multiply-accumulate datapath
`timescale 1ns/100ps
`include "mac_datapath_defs.vh"
module mac_datapath_properties #(
  parameter PM_AW = 12
) (
  // clock and reset
  input wire                   clock,
  input wire                   sys_rst,
  // operation port
  input wire                   op_valid,
  input wire [`OPCODE_W-1:0]   op_code,
  input wire [`IMM_MPY_W-1:0]  op_imm,
  input wire                   op_ready_ff,
  input wire                   op_done_ff,
  input wire                   int_inhibit_ff,
  // program memory and state
  input wire                   pm_rd_ff,
  input wire [PM_AW-1:0]       pm_addr_ff,
  input wire [`ACC_W-1:0]      acc_ff,
  input wire [`PROD_W-1:0]     product_ff,
  input wire [`OPND_W-1:0]     multiplicand_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire             take = op_valid && op_ready_ff;
  wire             mult = take && (op_code == `OP_MULTIPLY_MEMORY ||
                                   op_code == `OP_MULTIPLY_IMM);
  wire             acc_add = take && (op_code == `OP_ADD_PRODUCT ||
    op_code == `OP_LOAD_AND_ACC || op_code == `OP_LOAD_SHIFT_ACC);
  wire [PM_AW-1:0] acc_lo = acc_ff[PM_AW-1:0];
  // ----------
  // table read steps
  // ----------
  sequence tr_fetch;
    pm_rd_ff && !op_ready_ff;
  endsequence
  sequence tr_wait;
    !pm_rd_ff && !op_ready_ff ##1 op_ready_ff && op_done_ff;
  endsequence
  imm_product_a: assert property (
    take && op_code == `OP_MULTIPLY_IMM |=> $signed(product_ff) ==
    $signed($past(multiplicand_ff)) * $signed($past(op_imm)))
    else $error("immediate product wrong");
  prod_hold_a: assert property (!mult |=> $stable(product_ff))
    else $error("product changed without multiply");
  acc_add_a: assert property (
    acc_add |=> acc_ff == $past(acc_ff) + $past(product_ff))
    else $error("accumulate add wrong");
  acc_sub_a: assert property (
    take && op_code == `OP_SUBTRACT_PRODUCT |=>
    acc_ff == $past(acc_ff) - $past(product_ff))
    else $error("accumulate subtract wrong");
  acc_load_a: assert property (
    take && op_code == `OP_PRODUCT_TO_ACC |=> acc_ff == $past(product_ff))
    else $error("product load wrong");
  shift_keeps_acc_a: assert property (
    take && op_code == `OP_SHIFT_WORD_UP |=> $stable(acc_ff))
    else $error("word shift touched accumulator");
  int_block_a: assert property (
    take |=> int_inhibit_ff == $past(mult))
    else $error("interrupt inhibit wrong");
  one_cycle_done_a: assert property (
    take && op_code != `OP_TABLE_READ |=> op_done_ff)
    else $error("single-cycle op not done");
  table_steps_a: assert property (
    take && op_code == `OP_TABLE_READ |=> tr_fetch ##1 tr_wait)
    else $error("table read step order wrong");
  table_addr_a: assert property (
    take && op_code == `OP_TABLE_READ |=> pm_addr_ff == $past(acc_lo))
    else $error("table read source address wrong");
endmodule

/* File: pmem_model.sv */
// program memory model answering table-read fetches
`timescale 1ns/100ps
module pmem_model (
  // request
  input  wire        clock,
  input  wire        pm_rd_ff,
  input  wire [11:0] pm_addr_ff,
  // answer
  output reg  [15:0] pm_rdata
);
  initial pm_rdata = 16'h0000;
  // full word in the cycle after the request
  // off the answer cycle the bus keeps moving so stale data cannot pass
  always @(posedge clock) begin
    pm_rdata <= pm_rd_ff ? {4'hA, pm_addr_ff} : ~pm_rdata;
  end
endmodule

/* File: tb.sv */
// self-checking testbench for the multiply-accumulate datapath
`timescale 1ns/100ps
`include "mac_datapath_defs.vh"
module tb;
  logic        clock, sys_rst, op_valid, op_aux_sel, dm_wr_en;
  logic        op_ready_ff, op_done_ff, int_inhibit_ff, pm_rd_ff;
  logic [3:0]  op_code;
  logic [7:0]  op_addr, dm_wr_addr, dm_rd_addr;
  logic [12:0] op_imm;
  logic [15:0] dm_wr_data, pm_rdata, dm_rd_data_ff;
  logic [15:0] multiplicand_ff, aux0_ff, aux1_ff;
  logic [11:0] pm_addr_ff;
  logic [31:0] acc_ff, product_ff;
  int          miscompares, samples_checked;
  mac_datapath u_dut (.clock(clock), .sys_rst(sys_rst),
    .op_valid(op_valid), .op_code(op_code), .op_addr(op_addr),
    .op_imm(op_imm), .op_aux_sel(op_aux_sel), .op_ready_ff(op_ready_ff),
    .op_done_ff(op_done_ff), .int_inhibit_ff(int_inhibit_ff),
    .pm_rd_ff(pm_rd_ff), .pm_addr_ff(pm_addr_ff), .pm_rdata(pm_rdata),
    .dm_wr_en(dm_wr_en), .dm_wr_addr(dm_wr_addr), .dm_wr_data(dm_wr_data),
    .dm_rd_addr(dm_rd_addr), .dm_rd_data_ff(dm_rd_data_ff),
    .acc_ff(acc_ff), .product_ff(product_ff),
    .multiplicand_ff(multiplicand_ff), .aux0_ff(aux0_ff), .aux1_ff(aux1_ff));
  pmem_model u_pmem (.clock(clock), .pm_rd_ff(pm_rd_ff),
    .pm_addr_ff(pm_addr_ff), .pm_rdata(pm_rdata));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic tally_and_finish;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // returns 1 ns after the taking edge, so results must already show
  task automatic issue(input logic [3:0] c, input logic [7:0] a,
                       input logic [12:0] i);
    int n;
    n = 0;
    @(posedge clock);
    #1;
    while (op_ready_ff !== 1'b1) begin
      n++;
      if (n > 20) begin
        miscompares++;
        tally_and_finish;
      end
      @(posedge clock);
      #1;
    end
    op_code = c;
    op_addr = a;
    op_imm = i;
    op_valid = 1'b1;
    @(posedge clock);
    #1;
    op_valid = 1'b0;
  endtask
  task automatic dm_put(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    dm_wr_en = 1'b1;
    dm_wr_addr = a;
    dm_wr_data = d;
    @(posedge clock);
    #1;
    dm_wr_en = 1'b0;
  endtask
  task automatic dm_peek(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    #1;
    dm_rd_addr = a;
    @(posedge clock);
    #1;
    chk(dm_rd_data_ff, e);
  endtask
  task automatic sc_mac;
    dm_put(8'h04, 16'hFFFD);
    dm_put(8'h05, 16'h0007);
    dm_put(8'h06, 16'h8000);
    issue(`OP_LOAD_MULTIPLICAND, 8'h04, 13'h0000);
    chk(multiplicand_ff, 32'h0000FFFD);
    chk(op_done_ff, 32'h1);
    issue(`OP_MULTIPLY_MEMORY, 8'h05, 13'h0000);
    chk(product_ff, 32'hFFFFFFEB);
    chk(int_inhibit_ff, 32'h1);
    issue(`OP_PRODUCT_TO_ACC, 8'h00, 13'h0000);
    chk(acc_ff, 32'hFFFFFFEB);
    chk(int_inhibit_ff, 32'h0);
    issue(`OP_MULTIPLY_IMM, 8'h00, 13'h1000);
    chk(product_ff, 32'h00003000);
    issue(`OP_ADD_PRODUCT, 8'h00, 13'h0000);
    chk(acc_ff, 32'h00002FEB);
    issue(`OP_SUBTRACT_PRODUCT, 8'h00, 13'h0000);
    chk(acc_ff, 32'hFFFFFFEB);
    chk(product_ff, 32'h00003000);
    issue(`OP_LOAD_MULTIPLICAND, 8'h06, 13'h0000);
    issue(`OP_MULTIPLY_MEMORY, 8'h06, 13'h0000);
    chk(product_ff, 32'h40000000);
  endtask
  task automatic sc_pipe;
    dm_put(8'h10, 16'h0002);
    dm_put(8'h20, 16'h1234);
    issue(`OP_LOAD_AND_ACC, 8'h10, 13'h0000);
    chk(multiplicand_ff, 32'h00000002);
    chk(acc_ff, 32'h3FFFFFEB);
    issue(`OP_LOAD_SHIFT_ACC, 8'h20, 13'h0000);
    chk(multiplicand_ff, 32'h00001234);
    chk(acc_ff, 32'h7FFFFFEB);
    dm_peek(8'h21, 16'h1234);
    issue(`OP_SHIFT_WORD_UP, 8'h10, 13'h0000);
    chk(acc_ff, 32'h7FFFFFEB);
    dm_peek(8'h11, 16'h0002);
    // the top word has no neighbour: nothing may wrap into word 0
    dm_put(8'h00, 16'h5A5A);
    dm_put(8'hFF, 16'h0123);
    issue(`OP_SHIFT_WORD_UP, 8'hFF, 13'h0000);
    chk(acc_ff, 32'h7FFFFFEB);
    dm_peek(8'h00, 16'h5A5A);
    dm_peek(8'hFF, 16'h0123);
  endtask
  task automatic sc_short_and_table;
    issue(`OP_LOAD_ACC_SHORT, 8'h00, 13'h1FA5);
    chk(acc_ff, 32'h000000A5);
    op_aux_sel = 1'b1;
    issue(`OP_LOAD_AUX_SHORT, 8'h00, 13'h00C3);
    chk(aux1_ff, 32'h000000C3);
    op_aux_sel = 1'b0;
    issue(`OP_LOAD_AUX_SHORT, 8'h00, 13'h1E5A);
    chk(aux0_ff, 32'h0000005A);
    issue(`OP_TABLE_READ, 8'h30, 13'h0000);
    chk(pm_addr_ff, 32'h000000A5);
    chk(op_ready_ff, 32'h0);
    @(posedge clock);
    #1;
    chk(op_ready_ff, 32'h0);
    @(posedge clock);
    #1;
    chk(op_ready_ff, 32'h1);
    chk(op_done_ff, 32'h1);
    dm_peek(8'h30, 16'hA0A5);
  endtask
  initial begin
    sys_rst = 1'b1;
    op_valid = 1'b0;
    op_code = 4'h0;
    op_addr = 8'h00;
    op_imm = 13'h0000;
    op_aux_sel = 1'b0;
    dm_wr_en = 1'b0;
    dm_wr_addr = 8'h00;
    dm_wr_data = 16'h0000;
    dm_rd_addr = 8'h00;
    miscompares = 0;
    samples_checked = 0;
    repeat (12) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    sc_mac;
    sc_pipe;
    sc_short_and_table;
    tally_and_finish;
  end
endmodule
bind mac_datapath mac_datapath_properties #(.PM_AW(PM_AW)) u_props (
  .clock(clock), .sys_rst(sys_rst), .op_valid(op_valid),
  .op_code(op_code), .op_imm(op_imm), .op_ready_ff(op_ready_ff),
  .op_done_ff(op_done_ff), .int_inhibit_ff(int_inhibit_ff),
  .pm_rd_ff(pm_rd_ff), .pm_addr_ff(pm_addr_ff), .acc_ff(acc_ff),
  .product_ff(product_ff), .multiplicand_ff(multiplicand_ff));
